/* File: cpm_control_pin_mux.sv */
`timescale 1ns/1ns
// Functional notes
// - Five control pins, each given one function from configuration.
// - Configuration also selects inversion and drive strength per pin.
// - Transmit-enable function drives the RS485 driver enable.
// - Power enable low once configured, high while suspended.
// - Send LED pulses low on USB transmit activity.
// - Receive LED pulses low on USB receive activity.
// - Combined LED pulses low on either activity.
// - Sleep pin low throughout suspend, high otherwise.
// - Clock outputs of 48, 24, 12 or 6 MHz on any pin.
// - Clock outputs stop during suspend and resume afterwards.
// - GPIO only on pins 0 to 3, each enabled separately.
// - GPIO works alongside normal serial operation.
// - Write and read strobes only on pins 0 to 3, both modes.
// - Bit-bang turns the eight serial lines into a parallel port.
// - Async bit-bang paces output bytes by the prescaler timer.
// - Internal read and write strobes are brought out.
// - Sync bit-bang samples the port only on a write.
// - Defaults: send LED, receive LED, RS485 enable, power, sleep.
// - Input pins pulled up, optionally pulled low in suspend.
module cpm_control_pin_mux #(
	parameter int unsigned LED_PULSE_CYCLES = cpm_pkg::LED_PULSE_CYC
) (
	// Clock and reset
	input  wire logic                         sys_clk,
	input  wire logic                         reset,
	// Configuration memory
	input  wire logic                         cfg_valid,
	input  wire logic                         cfg_blank,
	input  wire logic [cpm_pkg::PIN_N-1:0][cpm_pkg::FUNC_W-1:0] cfg_func,
	input  wire logic [cpm_pkg::PIN_N-1:0]    cfg_pin_invert,
	input  wire logic [cpm_pkg::PIN_N-1:0]    cfg_pin_drive,
	input  wire logic [cpm_pkg::LINE_W-1:0]   cfg_line_invert,
	input  wire logic [cpm_pkg::LINE_W-1:0]   cfg_line_drive,
	input  wire logic                         cfg_suspend_pulldown,
	// USB and UART status
	input  wire logic                         usb_configured,
	input  wire logic                         usb_suspend,
	input  wire logic                         tx_activity,
	input  wire logic                         rx_activity,
	input  wire logic                         rs485_tx_active,
	input  wire logic [cpm_pkg::TAP_N-1:0]    ref_clk_taps,
	// GPIO on control pins
	input  wire logic [cpm_pkg::GPIO_PIN_N-1:0] gpio_out,
	input  wire logic [cpm_pkg::GPIO_PIN_N-1:0] gpio_oe,
	output logic      [cpm_pkg::GPIO_PIN_N-1:0] gpio_in,
	// Parallel port control
	input  wire logic [1:0]                   bb_mode,
	input  wire logic [cpm_pkg::PRESC_W-1:0]  bb_prescale,
	input  wire logic [cpm_pkg::LINE_W-1:0]   bb_dir,
	input  wire logic                         bb_wr_valid,
	input  wire logic [cpm_pkg::LINE_W-1:0]   bb_wr_data,
	output logic                              bb_wr_ack,
	output logic                              bb_rd_valid,
	output logic      [cpm_pkg::LINE_W-1:0]   bb_rd_data,
	// Normal UART drive of the serial lines
	input  wire logic [cpm_pkg::LINE_W-1:0]   uart_out,
	input  wire logic [cpm_pkg::LINE_W-1:0]   uart_oe,
	output logic      [cpm_pkg::LINE_W-1:0]   uart_in,
	// Serial line pins
	input  wire logic [cpm_pkg::LINE_W-1:0]   line_in,
	output logic      [cpm_pkg::LINE_W-1:0]   line_out,
	output logic      [cpm_pkg::LINE_W-1:0]   line_oe,
	output logic      [cpm_pkg::LINE_W-1:0]   line_drive_hi,
	// Control pins
	input  wire logic [cpm_pkg::PIN_N-1:0]    config_ctrl_pins_in,
	output logic      [cpm_pkg::PIN_N-1:0]    config_ctrl_pins_out,
	output logic      [cpm_pkg::PIN_N-1:0]    config_ctrl_pins_oe,
	output logic      [cpm_pkg::PIN_N-1:0]    pin_drive_hi,
	output logic      [cpm_pkg::PIN_N-1:0]    pin_pullup,
	output logic      [cpm_pkg::PIN_N-1:0]    pin_pulldown
);
	localparam int PN = cpm_pkg::PIN_N;
	localparam int LW = cpm_pkg::LINE_W;
	localparam int GN = cpm_pkg::GPIO_PIN_N;

	logic                                 cfg_latched;
	logic [PN-1:0][cpm_pkg::FUNC_W-1:0]   pin_func;
	logic [PN-1:0]                        pin_inv;
	logic [LW-1:0]                        line_inv;
	logic                                 sus_pulldown;
	logic [cpm_pkg::IN_W-1:0]             in_s1;
	logic [cpm_pkg::IN_W-1:0]             in_s2;
	logic [cpm_pkg::IN_W-1:0]             in_s3;
	logic [cpm_pkg::IN_W-1:0]             in_stable;
	logic [cpm_pkg::PRESC_W-1:0]          bb_timer;
	logic                                 bb_tick;
	logic                                 bb_due;
	cpm_pkg::cpm_bb_state_e               bb_state;
	logic [LW-1:0]                        bb_data;
	logic                                 wr_strobe_n;
	logic                                 rd_strobe_n;
	logic                                 bb_take;
	logic                                 bb_poll;
	logic [cpm_pkg::LED_N-1:0]            led_on;
	logic [cpm_pkg::LED_N-1:0]            act_evt;
	logic [PN-1:0]                        gpio_ext_out;
	logic [PN-1:0]                        gpio_ext_oe;
	logic [PN-1:0]                        next_pin_out;
	logic [PN-1:0]                        next_pin_oe;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cfg_latched   <= 1'b0;
			pin_func      <= cpm_pkg::FN_DEFAULT;
			pin_inv       <= '0;
			pin_drive_hi  <= '0;
			line_inv      <= '0;
			line_drive_hi <= '0;
			sus_pulldown  <= 1'b0;
		end else if (cfg_valid && !cfg_latched) begin
			cfg_latched   <= 1'b1;
			pin_func      <= cfg_blank ? cpm_pkg::FN_DEFAULT : cfg_func;
			pin_inv       <= cfg_pin_invert;
			pin_drive_hi  <= cfg_pin_drive;
			line_inv      <= cfg_line_invert;
			line_drive_hi <= cfg_line_drive;
			sus_pulldown  <= cfg_suspend_pulldown;
		end
	end

	// Pin inputs: a bit moves only when the second and third stages agree
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			in_s1     <= '0;
			in_s2     <= '0;
			in_s3     <= '0;
			in_stable <= '0;
		end else begin
			in_s1     <= {config_ctrl_pins_in, line_in};
			in_s2     <= in_s1;
			in_s3     <= in_s2;
			in_stable <= (in_s2 & ~(in_s2 ^ in_s3))
				| (in_stable & (in_s2 ^ in_s3));
		end
	end

	// GPIO and UART paths stay independent of each other
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			gpio_in <= '0;
			uart_in <= '0;
		end else begin
			gpio_in <= in_stable[LW +: GN];
			uart_in <= in_stable[LW-1:0] ^ line_inv;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset || bb_mode != cpm_pkg::BB_ASYNC) begin
			bb_timer <= '0;
			bb_tick  <= 1'b0;
		end else if (bb_timer == '0) begin
			bb_timer <= bb_prescale;
			bb_tick  <= 1'b1;
		end else begin
			bb_timer <= bb_timer - 1'b1;
			bb_tick  <= 1'b0;
		end
	end

	assign bb_take = bb_state == cpm_bb_idle() && bb_wr_valid
		&& (bb_mode == cpm_pkg::BB_SYNC
		|| (bb_mode == cpm_pkg::BB_ASYNC && bb_due));
	assign bb_poll = bb_state == cpm_bb_idle() && !bb_take
		&& bb_mode == cpm_pkg::BB_ASYNC && bb_due;

	function automatic cpm_pkg::cpm_bb_state_e cpm_bb_idle();
		return cpm_pkg::BB_IDLE;
	endfunction

	// A tick that lands while a transfer is busy is kept, not dropped
	always_ff @(posedge sys_clk) begin
		if (reset || bb_mode != cpm_pkg::BB_ASYNC) begin
			bb_due <= 1'b0;
		end else begin
			bb_due <= bb_tick || (bb_due && !bb_take && !bb_poll);
		end
	end

	// write then read strobe per byte written; an async poll gives the read strobe alone
	// sync mode samples only after a write
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			bb_state    <= cpm_pkg::BB_IDLE;
			bb_data     <= '0;
			bb_wr_ack   <= 1'b0;
			wr_strobe_n <= 1'b1;
			rd_strobe_n <= 1'b1;
			bb_rd_valid <= 1'b0;
			bb_rd_data  <= '0;
		end else begin
			bb_wr_ack   <= 1'b0;
			wr_strobe_n <= 1'b1;
			rd_strobe_n <= 1'b1;
			bb_rd_valid <= 1'b0;
			case (bb_state)
				cpm_pkg::BB_IDLE: begin
					if (bb_take) begin
						bb_data   <= bb_wr_data;
						bb_wr_ack <= 1'b1;
						bb_state  <= cpm_pkg::BB_WRITE;
					end else if (bb_poll) begin
						bb_state <= cpm_pkg::BB_READ;
					end
				end
				cpm_pkg::BB_WRITE: begin
					wr_strobe_n <= 1'b0;
					bb_state    <= cpm_pkg::BB_READ;
				end
				cpm_pkg::BB_READ: begin
					// Sample lags the pins by the input synchroniser
					rd_strobe_n <= 1'b0;
					bb_rd_valid <= 1'b1;
					bb_rd_data  <= in_stable[LW-1:0] ^ line_inv;
					bb_state    <= cpm_pkg::BB_IDLE;
				end
				default: begin
					bb_state <= cpm_pkg::BB_IDLE;
				end
			endcase
		end
	end

	// serial lines become the parallel port
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			line_out <= '0;
			line_oe  <= '0;
		end else if (bb_mode != cpm_pkg::BB_OFF) begin
			line_out <= bb_data ^ line_inv;
			line_oe  <= bb_dir;
		end else begin
			line_out <= uart_out ^ line_inv;
			line_oe  <= uart_oe;
		end
	end

	assign act_evt[cpm_pkg::LED_TX]  = tx_activity;
	assign act_evt[cpm_pkg::LED_RX]  = rx_activity;
	assign act_evt[cpm_pkg::LED_ANY] = tx_activity || rx_activity;

	cpm_pulse_if led_bus[cpm_pkg::LED_N] ();

	for (genvar e = 0; e < cpm_pkg::LED_N; e++) begin : g_led
		assign led_bus[e].event_pulse = act_evt[e];
		assign led_on[e]              = led_bus[e].led_on;
		cpm_led_stretch #(
			.PULSE_CYCLES (LED_PULSE_CYCLES)
		) u_stretch (
			.sys_clk (sys_clk),
			.reset   (reset),
			.pl      (led_bus[e])
		);
	end

	assign gpio_ext_out = {{(PN - GN){1'b0}}, gpio_out};
	assign gpio_ext_oe  = {{(PN - GN){1'b0}}, gpio_oe};

	for (genvar p = 0; p < PN; p++) begin : g_pin
		localparam bit LOW_PIN = p < GN;
		logic lvl;
		logic drv;

		always_comb begin
			lvl = 1'b1;
			drv = 1'b1;
			case (pin_func[p])
				cpm_pkg::FN_DRV_EN: lvl = !rs485_tx_active;
				cpm_pkg::FN_POWER: lvl = !(usb_configured && !usb_suspend);
				cpm_pkg::FN_SEND_LED: lvl = !led_on[cpm_pkg::LED_TX];
				cpm_pkg::FN_RECV_LED: lvl = !led_on[cpm_pkg::LED_RX];
				cpm_pkg::FN_ANYLED: lvl = !led_on[cpm_pkg::LED_ANY];
				cpm_pkg::FN_SLEEP: lvl = !usb_suspend;
				cpm_pkg::FN_CLK_48M:
					lvl = ref_clk_taps[cpm_pkg::TAP_48] && !usb_suspend;
				cpm_pkg::FN_CLK_24M:
					lvl = ref_clk_taps[cpm_pkg::TAP_24] && !usb_suspend;
				cpm_pkg::FN_CLK_12M:
					lvl = ref_clk_taps[cpm_pkg::TAP_12] && !usb_suspend;
				cpm_pkg::FN_CLK_6M:
					lvl = ref_clk_taps[cpm_pkg::TAP_6] && !usb_suspend;
				// GPIO on the low four pins only
				cpm_pkg::FN_GPIO: begin
					lvl = gpio_ext_out[p];
					drv = LOW_PIN && gpio_ext_oe[p];
				end
				// strobes on the low four pins only
				cpm_pkg::FN_WRSTB: begin
					lvl = wr_strobe_n;
					drv = LOW_PIN;
				end
				cpm_pkg::FN_RDSTB: begin
					lvl = rd_strobe_n;
					drv = LOW_PIN;
				end
				default: drv = 1'b0;
			endcase
			// hold off until configuration is latched
			if (!cfg_latched) begin
				drv = 1'b0;
			end
		end

		assign next_pin_out[p] = lvl ^ pin_inv[p];
		assign next_pin_oe[p]  = drv;

		a_rs485_drive_enable_n_level: assert property (
			cfg_latched && pin_func[p] == cpm_pkg::FN_DRV_EN |=>
			config_ctrl_pins_out[p] == (!$past(rs485_tx_active) ^ pin_inv[p])
			&& config_ctrl_pins_oe[p])
			else $error("rs485 enable pin wrong");

		a_power_level: assert property (
			cfg_latched && pin_func[p] == cpm_pkg::FN_POWER && !pin_inv[p]
			&& usb_configured && !usb_suspend |=>
			!config_ctrl_pins_out[p])
			else $error("power switch not on after configuration");

		a_sleep_level: assert property (
			cfg_latched && pin_func[p] == cpm_pkg::FN_SLEEP && !pin_inv[p]
			|=> config_ctrl_pins_out[p] == !$past(usb_suspend))
			else $error("sleep pin does not follow suspend");

		a_clock_stops: assert property (
			cfg_latched && pin_func[p] >= cpm_pkg::FN_CLK_48M
			&& pin_func[p] <= cpm_pkg::FN_CLK_6M && usb_suspend [*2] |=>
			config_ctrl_pins_out[p] == pin_inv[p])
			else $error("clock output runs during suspend");

		a_led_pulse_low: assert property (
			cfg_latched && pin_func[p] == cpm_pkg::FN_SEND_LED && !pin_inv[p]
			&& tx_activity |=> ##1 !config_ctrl_pins_out[p])
			else $error("send led did not pulse");
	end

	// pull-up on inputs, optional pull-down in suspend
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			config_ctrl_pins_out <= '1;
			config_ctrl_pins_oe  <= '0;
			pin_pullup           <= '1;
			pin_pulldown         <= '0;
		end else begin
			config_ctrl_pins_out <= next_pin_out;
			config_ctrl_pins_oe  <= next_pin_oe;
			pin_pullup   <= ~next_pin_oe & {PN{!(usb_suspend && sus_pulldown)}};
			pin_pulldown <= ~next_pin_oe & {PN{usb_suspend && sus_pulldown}};
		end
	end

	sequence s_sync_take;
		bb_mode == cpm_pkg::BB_SYNC && bb_take;
	endsequence

	sequence s_write_then_read;
		##1 bb_wr_ack ##1 !wr_strobe_n ##1 (!rd_strobe_n && bb_rd_valid);
	endsequence

	a_sync_exchange: assert property (
		s_sync_take |-> s_write_then_read)
		else $error("sync write not followed by strobed sample");

	a_sync_no_idle_read: assert property (
		bb_mode == cpm_pkg::BB_SYNC && $stable(bb_mode) && $fell(rd_strobe_n)
		|-> !$past(wr_strobe_n))
		else $error("sync mode sampled without a write");

	a_async_paced: assert property (
		bb_mode == cpm_pkg::BB_ASYNC && bb_wr_ack |-> $past(bb_due))
		else $error("async byte taken without timer tick");

	a_cfg_holdoff: assert property (
		!cfg_latched |=> config_ctrl_pins_oe == '0)
		else $error("pin driven before configuration latched");

	a_pin4_no_gpio: assert property (
		pin_func[PN-1] >= cpm_pkg::FN_GPIO |=>
		!config_ctrl_pins_oe[PN-1])
		else $error("high pin driven by gpio or strobe");

	a_line_port: assert property (
		bb_mode != cpm_pkg::BB_OFF |=>
		line_out == ($past(bb_data) ^ line_inv)
		&& line_oe == $past(bb_dir))
		else $error("serial lines not carrying parallel port");
endmodule

/* File: cpm_control_pin_mux_tb_top.sv */
`timescale 1ns/1ns
module cpm_control_pin_mux_tb_top;
	typedef struct packed {
		logic       cfgd;
		logic       susp;
		logic       txon;
		logic [4:0] exp;
	} cpm_row_s;
	logic sys_clk, reset, cfg_valid, cfg_blank, cfg_suspend_pulldown;
	logic usb_configured, usb_suspend, tx_activity, rx_activity;
	logic rs485_tx_active, bb_wr_valid, bb_wr_ack, bb_rd_valid;
	logic [cpm_pkg::PIN_N-1:0][cpm_pkg::FUNC_W-1:0] cfg_func;
	logic [4:0]  cfg_pin_invert, cfg_pin_drive, pins_in, pins_out, pins_oe;
	logic [4:0]  pin_drive_hi, pin_pullup, pin_pulldown;
	logic [7:0]  cfg_line_invert, cfg_line_drive, bb_dir, bb_wr_data;
	logic [7:0]  bb_rd_data, uart_out, uart_oe, uart_in, line_in, line_out;
	logic [7:0]  line_oe, line_drive_hi, ext_line;
	logic [3:0]  ref_clk_taps, gpio_out, gpio_oe, gpio_in;
	logic [1:0]  bb_mode;
	logic [13:0] bb_prescale;
	int          n_mismatch, checks, cyc, lowc[5], togc[5];
	cpm_row_s    rows [4] = '{'{1'h1, 1'h0, 1'h0, 5'h17},
		'{1'h1, 1'h0, 1'h1, 5'h13}, '{1'h0, 1'h0, 1'h0, 5'h1f},
		'{1'h1, 1'h1, 1'h0, 5'h0f}};

	cpm_control_pin_mux #(.LED_PULSE_CYCLES(16)) cpm_control_pin_mux_inst (
		.sys_clk(sys_clk), .reset(reset), .cfg_valid(cfg_valid),
		.cfg_blank(cfg_blank), .cfg_func(cfg_func),
		.cfg_pin_invert(cfg_pin_invert), .cfg_pin_drive(cfg_pin_drive),
		.cfg_line_invert(cfg_line_invert), .cfg_line_drive(cfg_line_drive),
		.cfg_suspend_pulldown(cfg_suspend_pulldown),
		.usb_configured(usb_configured), .usb_suspend(usb_suspend),
		.tx_activity(tx_activity), .rx_activity(rx_activity),
		.rs485_tx_active(rs485_tx_active), .ref_clk_taps(ref_clk_taps),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
		.bb_mode(bb_mode), .bb_prescale(bb_prescale), .bb_dir(bb_dir),
		.bb_wr_valid(bb_wr_valid), .bb_wr_data(bb_wr_data),
		.bb_wr_ack(bb_wr_ack), .bb_rd_valid(bb_rd_valid),
		.bb_rd_data(bb_rd_data), .uart_out(uart_out), .uart_oe(uart_oe),
		.uart_in(uart_in), .line_in(line_in), .line_out(line_out),
		.line_oe(line_oe), .line_drive_hi(line_drive_hi),
		.config_ctrl_pins_in(pins_in), .config_ctrl_pins_out(pins_out),
		.config_ctrl_pins_oe(pins_oe), .pin_drive_hi(pin_drive_hi),
		.pin_pullup(pin_pullup), .pin_pulldown(pin_pulldown));

	cpm_ext_model cpm_ext_model_inst (
		.pins_out(pins_out), .pins_oe(pins_oe), .pull_hi(pin_pullup),
		.pull_lo(pin_pulldown), .line_out(line_out), .line_oe(line_oe),
		.ext_line(ext_line), .pins_in(pins_in), .line_in(line_in));

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// Stand-in clock chain: bit 0 toggles every cycle, bit 3 every eighth
	always @(posedge sys_clk) begin
		ref_clk_taps <= ref_clk_taps + 4'h1;
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Counts low cycles and toggles per pin over n sampled cycles
	task automatic watch(input int n);
		logic [4:0] last;
		// Reference taken off the edge so the first toggle is not raced
		@(negedge sys_clk);
		last = pins_out;
		for (int p = 0; p < 5; p++) begin
			lowc[p] = 0;
			togc[p] = 0;
		end
		repeat (n) begin
			@(negedge sys_clk);
			for (int p = 0; p < 5; p++) begin
				if (pins_out[p] === 1'b0)
					lowc[p]++;
				if (pins_out[p] !== last[p])
					togc[p]++;
			end
			last = pins_out;
		end
		@(posedge sys_clk);
	endtask

	task automatic start(input logic blank, input logic [19:0] fn,
		input logic [4:0] inv, input logic [4:0] drv);
		reset <= 1'b1;
		cfg_valid <= 1'b0;
		cfg_blank <= blank;
		cfg_func <= fn;
		cfg_pin_invert <= inv;
		cfg_pin_drive <= drv;
		step(2);
		@(negedge sys_clk);
		chk(pins_oe, 5'h00);
		chk(pin_pullup, 5'h1f);
		@(posedge sys_clk);
		reset <= 1'b0;
		step(3);
		@(negedge sys_clk);
		chk(pins_oe, 5'h00);
		@(posedge sys_clk);
		cfg_valid <= 1'b1;
		step(3);
	endtask

	task automatic pulse(input logic rx, input int gap);
		step(1);
		tx_activity <= ~rx;
		rx_activity <= rx;
		step(1);
		tx_activity <= 1'b0;
		rx_activity <= 1'b0;
		if (gap > 0) begin
			step(gap - 1);
			rx_activity <= rx;
			tx_activity <= ~rx;
			step(1);
			tx_activity <= 1'b0;
			rx_activity <= 1'b0;
		end
	endtask

	// Sync access: pin 0 carries the write strobe, pin 1 the read strobe
	task automatic xfer(input logic [7:0] d, input logic [7:0] exp);
		int ack_at, wr_at, rd_at, rv_at;
		logic [7:0] got;
		ack_at = -1;
		wr_at = -1;
		rd_at = -1;
		rv_at = -1;
		got = 8'h00;
		bb_wr_data <= d;
		bb_wr_valid <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			@(negedge sys_clk);
			if (bb_wr_ack === 1'b1)
				ack_at = i;
			if (pins_out[0] === 1'b0)
				wr_at = i;
			if (pins_out[1] === 1'b0)
				rd_at = i;
			if (bb_rd_valid === 1'b1) begin
				rv_at = i;
				got = bb_rd_data;
			end
			@(posedge sys_clk);
			if (ack_at >= 0)
				bb_wr_valid <= 1'b0;
		end
		// Strobe pins are registered once more than the internal strobes
		chk(wr_at, ack_at + 2);
		chk(rd_at, ack_at + 3);
		chk(rv_at, ack_at + 2);
		chk(got, exp);
	endtask

	initial begin
		reset = 1'b1;
		{cfg_valid, cfg_blank, cfg_suspend_pulldown} = 3'h0;
		{usb_configured, usb_suspend, tx_activity, rx_activity} = 4'h0;
		{rs485_tx_active, bb_wr_valid, bb_mode, bb_prescale} = 18'h0;
		{cfg_func, cfg_pin_invert, cfg_pin_drive} = 30'h0;
		{cfg_line_invert, cfg_line_drive, bb_dir, bb_wr_data} = 32'h0;
		{uart_out, uart_oe, ext_line} = 24'h0;
		{ref_clk_taps, gpio_out, gpio_oe} = 12'h0;
		n_mismatch = 0;
		checks = 0;
		cyc = 0;
		start(1'b1, 20'h0, 5'h00, 5'h00);
		cfg_blank <= 1'b0;
		cfg_func <= {5{cpm_pkg::FN_GPIO}};
		for (int r = 0; r < 4; r++) begin
			usb_configured <= rows[r].cfgd;
			usb_suspend <= rows[r].susp;
			rs485_tx_active <= rows[r].txon;
			step(3);
			@(negedge sys_clk);
			chk(pins_out, rows[r].exp);
			chk(pins_oe, 5'h1f);
			@(posedge sys_clk);
		end
		usb_suspend <= 1'b0;
		fork watch(40); pulse(1'b0, 0); join
		chk(lowc[0], 16);
		chk(lowc[1], 0);
		fork watch(40); pulse(1'b1, 5); join
		chk(lowc[1], 21);
		chk(lowc[0], 0);

		cfg_suspend_pulldown <= 1'b1;
		cfg_line_drive <= 8'h3c;
		start(1'b0, {cpm_pkg::FN_GPIO, cpm_pkg::FN_GPIO, cpm_pkg::FN_CLK_6M,
			cpm_pkg::FN_CLK_48M, cpm_pkg::FN_ANYLED}, 5'h01, 5'h15);
		gpio_oe <= 4'h8;
		gpio_out <= 4'h0;
		uart_oe <= 8'hff;
		uart_out <= 8'ha5;
		// Pin inputs need six edges through the synchroniser
		step(7);
		chk(pin_drive_hi, 5'h15);
		chk(line_drive_hi, 8'h3c);
		chk({pins_oe[4], pin_pullup[4]}, 2'h1);
		chk({pins_oe[3], pins_out[3], gpio_in[3]}, 3'h4);
		chk({line_out, line_oe, uart_in}, 24'ha5ffa5);
		gpio_out <= 4'h8;
		step(7);
		chk(gpio_in[3], 1'h1);
		fork watch(40); pulse(1'b1, 0); join
		chk(40 - lowc[0], 16);
		watch(16);
		chk(togc[1], 16);
		chk(togc[2], 2);
		usb_suspend <= 1'b1;
		step(3);
		watch(16);
		chk(togc[1], 0);
		chk(togc[2], 0);
		chk({pins_out[2:1], pin_pulldown[4]}, 3'h1);
		usb_suspend <= 1'b0;
		step(3);
		watch(8);
		chk(togc[1], 8);

		start(1'b0, {cpm_pkg::FN_RDSTB, cpm_pkg::FN_SEND_LED, cpm_pkg::FN_POWER,
			cpm_pkg::FN_RDSTB, cpm_pkg::FN_WRSTB}, 5'h00, 5'h00);
		chk({pins_oe[4], pins_out[1:0]}, 3'h3);
		bb_mode <= cpm_pkg::BB_SYNC;
		bb_dir <= 8'hff;
		ext_line <= 8'h50;
		// A sync read returns the settled port from before this byte landed
		step(6);
		xfer(8'h3c, 8'h00);
		chk({line_out, line_oe}, 16'h3cff);
		bb_dir <= 8'h0f;
		step(6);
		xfer(8'ha6, 8'h5c);
		bb_mode <= cpm_pkg::BB_ASYNC;
		bb_prescale <= 14'h0004;
		bb_dir <= 8'hff;
		step(5);
		lowc[0] = 0;
		repeat (50) begin
			@(negedge sys_clk);
			if (bb_rd_valid === 1'b1)
				lowc[0]++;
		end
		chk(lowc[0], 10);
		@(posedge sys_clk);
		bb_wr_data <= 8'h81;
		bb_wr_valid <= 1'b1;
		lowc[1] = 0;
		while (bb_wr_ack !== 1'b1 && lowc[1] < 10) begin
			@(negedge sys_clk);
			lowc[1]++;
		end
		@(posedge sys_clk);
		bb_wr_valid <= 1'b0;
		chk(lowc[1] < 10, 1'h1);
		step(20);
		lowc[2] = 0;
		while (bb_rd_valid !== 1'b1 && lowc[2] < 10) begin
			@(negedge sys_clk);
			lowc[2]++;
		end
		chk(bb_rd_data, 8'h81);
		conclude();
	end
endmodule

/* File: cpm_ext_model.sv */
`timescale 1ns/1ns
module cpm_ext_model (
	// Control pins as driven by the device
	input  wire logic [cpm_pkg::PIN_N-1:0]  pins_out,
	input  wire logic [cpm_pkg::PIN_N-1:0]  pins_oe,
	input  wire logic [cpm_pkg::PIN_N-1:0]  pull_hi,
	input  wire logic [cpm_pkg::PIN_N-1:0]  pull_lo,
	// Serial lines and the far-side logic driving them
	input  wire logic [cpm_pkg::LINE_W-1:0] line_out,
	input  wire logic [cpm_pkg::LINE_W-1:0] line_oe,
	input  wire logic [cpm_pkg::LINE_W-1:0] ext_line,
	// Resolved wire levels
	output logic      [cpm_pkg::PIN_N-1:0]  pins_in,
	output logic      [cpm_pkg::LINE_W-1:0] line_in
);
	// A floating pin with no pull shows the inverse of its last drive,
	// so a stale value can never pass for a good one
	always_comb begin
		for (int p = 0; p < cpm_pkg::PIN_N; p++) begin
			if (pins_oe[p] === 1'b1)
				pins_in[p] = pins_out[p];
			else if (pull_lo[p] === 1'b1)
				pins_in[p] = 1'b0;
			else if (pull_hi[p] === 1'b1)
				pins_in[p] = 1'b1;
			else
				pins_in[p] = ~pins_out[p];
		end
		for (int i = 0; i < cpm_pkg::LINE_W; i++)
			line_in[i] = line_oe[i] ? line_out[i] : ext_line[i];
	end
endmodule

/* File: cpm_led_stretch.sv */
`timescale 1ns/1ns
module cpm_led_stretch #(
	parameter int unsigned PULSE_CYCLES = cpm_pkg::LED_PULSE_CYC
) (
	// Clock and reset
	input wire logic         sys_clk,
	input wire logic         reset,
	// Event in, stretched level out
	cpm_pulse_if.stretch     pl
);
	localparam logic [cpm_pkg::LED_CNT_W-1:0] LOAD =
		cpm_pkg::LED_CNT_W'(PULSE_CYCLES - 1);

	logic [cpm_pkg::LED_CNT_W-1:0] remaining;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			remaining <= '0;
			pl.led_on <= 1'b0;
		end else if (pl.event_pulse) begin
			remaining <= LOAD;
			pl.led_on <= 1'b1;
		end else if (remaining != '0) begin
			remaining <= remaining - 1'b1;
		end else begin
			pl.led_on <= 1'b0;
		end
	end

	a_led_min_width: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(pl.led_on) |-> pl.led_on [*8])
		else $error("activity pulse shorter than minimum");
endmodule

/* File: cpm_pkg.sv */
package cpm_pkg;
	localparam int PIN_N      = 5;
	localparam int GPIO_PIN_N = 4;
	localparam int LINE_W     = 8;
	localparam int FUNC_W     = 4;
	localparam int PRESC_W    = 14;
	localparam int LED_CNT_W  = 20;
	localparam int IN_W       = PIN_N + LINE_W;

	// Function codes as stored in configuration memory
	localparam logic [FUNC_W-1:0] FN_DRV_EN   = 4'h0;
	localparam logic [FUNC_W-1:0] FN_POWER    = 4'h1;
	localparam logic [FUNC_W-1:0] FN_SEND_LED = 4'h2;
	localparam logic [FUNC_W-1:0] FN_RECV_LED = 4'h3;
	localparam logic [FUNC_W-1:0] FN_ANYLED = 4'h4;
	localparam logic [FUNC_W-1:0] FN_SLEEP = 4'h5;
	localparam logic [FUNC_W-1:0] FN_CLK_48M = 4'h6;
	localparam logic [FUNC_W-1:0] FN_CLK_24M = 4'h7;
	localparam logic [FUNC_W-1:0] FN_CLK_12M = 4'h8;
	localparam logic [FUNC_W-1:0] FN_CLK_6M  = 4'h9;
	localparam logic [FUNC_W-1:0] FN_GPIO  = 4'ha;
	localparam logic [FUNC_W-1:0] FN_WRSTB = 4'hb;
	localparam logic [FUNC_W-1:0] FN_RDSTB = 4'hc;

	localparam logic [PIN_N-1:0][FUNC_W-1:0] FN_DEFAULT =
		{FN_SLEEP, FN_POWER, FN_DRV_EN, FN_RECV_LED, FN_SEND_LED};

	// Parallel port modes
	localparam logic [1:0] BB_OFF   = 2'h0;
	localparam logic [1:0] BB_ASYNC = 2'h1;
	localparam logic [1:0] BB_SYNC  = 2'h2;

	// Activity LED sources and clock tap positions
	localparam int LED_TX  = 0;
	localparam int LED_RX  = 1;
	localparam int LED_ANY = 2;
	localparam int LED_N   = 3;
	localparam int TAP_48  = 0;
	localparam int TAP_24  = 1;
	localparam int TAP_12  = 2;
	localparam int TAP_6   = 3;
	localparam int TAP_N   = 4;

	localparam int CLK_PERIOD_NS = 20;
	localparam int LED_PULSE_NS  = 10_000_000;
	localparam int LED_PULSE_CYC =
		(LED_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {BB_IDLE, BB_WRITE, BB_READ} cpm_bb_state_e;
endpackage

/* File: cpm_pulse_if.sv */
`timescale 1ns/1ns
interface cpm_pulse_if;
	logic event_pulse;
	logic led_on;
	modport src (output event_pulse, input led_on);
	modport stretch (input event_pulse, output led_on);
endinterface
